/* File: core/ucf_cfg.svh */
// constants for the serial clock and framing block
`ifndef UCF_CFG_SVH
`define UCF_CFG_SVH

`define UCF_DIV_W        12
`define UCF_DATA_W       9
`define UCF_ENTRY_W      11
`define UCF_ENTRY_FE     9
`define UCF_ENTRY_PE     10
`define UCF_CS_9BIT      3'h7
`define UCF_CS_BASE      4'h5
`define UCF_NB_DEFAULT   4'h8
`define UCF_PM_EVEN      2'h2
`define UCF_PM_ODD       2'h3
`define UCF_TOP_NORMAL   4'hf
`define UCF_TOP_DOUBLE   4'h7
`define UCF_MID_NORMAL   4'h7
`define UCF_MID_DOUBLE   4'h3
`define UCF_RXBUF_DEPTH  2'h2

`endif

/* File: core/ucf_pkg.sv */
// types shared by the serial clock and framing block
package ucf_pkg;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_PAR,
		TX_STOP1,
		TX_STOP2
	} ucf_tx_st_t;

	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_PAR,
		RX_STOP
	} ucf_rx_st_t;

	typedef struct packed {
		ucf_tx_st_t  tx_st;
		logic [3:0]  tx_pre;
		logic [8:0]  tx_shift;
		logic [3:0]  tx_bitn;
		logic        tx_par;
		logic        tx_line;
		logic [8:0]  tx_buf;
		logic        tx_buf_full;
		logic        txc;
		logic        xck_int;
		logic        xck_s1;
		logic        xck_s2;
		logic        xck_d;
		ucf_rx_st_t  rx_st;
		logic [3:0]  rx_cnt;
		logic [8:0]  rx_shift;
		logic [3:0]  rx_bitn;
		logic        rx_pe;
		logic [10:0] buf0;
		logic [10:0] buf1;
		logic [1:0]  buf_cnt;
		logic        dor;
	} ucf_state_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic        tick;
	} ucf_baud_state_t;

endpackage : ucf_pkg

/* File: core/ucf_baud_gen.sv */
// down-counting baud rate generator
`timescale 1ns/1ps
`include "ucf_cfg.svh"

module ucf_baud_gen #(
	parameter int DIV_W = `UCF_DIV_W
) (
	input  wire logic             ref_clk,  // system clock
	input  wire logic             sys_rst,  // synchronous reset, high
	input  wire logic [DIV_W-1:0] divisor,  // baud divisor value
	input  wire logic             reload,   // low byte written
	output logic                  tick      // one pulse per count-out
);
	import ucf_pkg::*;

	generate
		if (DIV_W != `UCF_DIV_W) begin : g_chk
			$error("ucf_baud_gen: DIV_W must match the counter width");
		end
	endgenerate

	ucf_baud_state_t r_reg;
	ucf_baud_state_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.tick = (r_reg.cnt == 12'h000);
		if (reload || r_reg.cnt == 12'h000) begin
			r_next.cnt = divisor;
		end else begin
			r_next.cnt = r_reg.cnt - 12'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick = r_reg.tick;

endmodule : ucf_baud_gen

/* File: core/ucf_usart.sv */
// serial transmitter and receiver with clock generation and frame formatting
`timescale 1ns/1ps
`include "ucf_cfg.svh"

module ucf_usart #(
	parameter int DIV_W = `UCF_DIV_W
) (
	input  wire logic             ref_clk,             // system clock
	input  wire logic             sys_rst,             // synchronous reset, high
	input  wire logic             tx_enable,           // transmitter enable
	input  wire logic             rx_enable,           // receiver enable
	input  wire logic [7:0]       baud_divisor_low,    // divisor low byte
	input  wire logic [DIV_W-9:0] baud_divisor_high,   // divisor high bits
	input  wire logic             baud_divisor_low_wr, // low byte write pulse
	input  wire logic             double_speed,        // halve async divisor
	input  wire logic             sync_mode_select,    // 1 synchronous
	input  wire logic             xfer_clk_pin_dir,    // 1 output, master
	input  wire logic             clock_polarity,      // sync edge choice
	input  wire logic [2:0]       char_size,           // data bits code
	input  wire logic [1:0]       parity_mode,         // 0 none, 2 even, 3 odd
	input  wire logic             stop_bits_select,    // 1 two stop bits
	input  wire logic [8:0]       tx_data,             // character to send
	input  wire logic             tx_data_wr,          // write pulse
	input  wire logic             tx_complete_clr,     // clear pulse
	input  wire logic             rx_read,             // pop pulse
	input  wire logic             serial_in_pin,       // receive line
	input  wire logic             xfer_clk_pin_in,     // transfer clock in
	output logic                  xfer_clk_pin_out,    // transfer clock out
	output logic                  xfer_clk_pin_oe,     // clock pin drive
	output logic                  serial_out_pin,      // transmit line
	output logic                  serial_out_oe,       // transmit drive
	output logic                  tx_buf_empty,        // buffer empty request
	output logic                  tx_complete_flag,    // transmit complete
	output logic                  rx_complete_flag,    // unread data present
	output logic [8:0]            rx_data,             // oldest character
	output logic                  frame_error,         // with rx_data
	output logic                  parity_error,        // with rx_data
	output logic                  data_overrun         // sticky overrun
);
	import ucf_pkg::*;

	generate
		if (DIV_W != `UCF_DIV_W) begin : g_chk
			$error("ucf_usart: DIV_W must be twelve");
		end
	endgenerate

	function automatic logic [3:0] ucf_nbits(input logic [2:0] cs);
		if (cs == `UCF_CS_9BIT) begin
			return 4'h9;
		end else if (cs[2]) begin
			return `UCF_NB_DEFAULT;
		end
		return `UCF_CS_BASE + {2'b00, cs[1:0]};
	endfunction : ucf_nbits

	function automatic logic ucf_parity(
		input logic [8:0] d,
		input logic [3:0] nb,
		input logic       odd
	);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < nb) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction : ucf_parity

	ucf_state_t r_reg;
	ucf_state_t r_next;
	logic       b_tick;

	ucf_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.divisor({baud_divisor_high, baud_divisor_low}),
		.reload(baud_divisor_low_wr),
		.tick(b_tick)
	);

	logic       is_sync;
	logic       master;
	logic       slave;
	logic       ds;
	logic [3:0] top;
	logic [3:0] mid;
	logic       rise;
	logic       fall;
	logic       chg_e;
	logic       smp_e;
	logic       tx_tick;
	logic       rx_now;
	logic [3:0] nb;
	logic       par_on;
	logic       push;
	logic [10:0] entry;

	always_comb begin
		is_sync = sync_mode_select;
		master  = is_sync & xfer_clk_pin_dir;
		slave   = is_sync & ~xfer_clk_pin_dir;
		ds      = double_speed & ~is_sync;
		top     = ds ? `UCF_TOP_DOUBLE : `UCF_TOP_NORMAL;
		mid     = ds ? `UCF_MID_DOUBLE : `UCF_MID_NORMAL;
		// master edges come from the internal clock, slave edges from the pin
		rise  = (master & b_tick & ~r_reg.xck_int) |
			(slave & r_reg.xck_s2 & ~r_reg.xck_d);
		fall  = (master & b_tick & r_reg.xck_int) |
			(slave & ~r_reg.xck_s2 & r_reg.xck_d);
		chg_e = clock_polarity ? fall : rise;
		smp_e = clock_polarity ? rise : fall;
		tx_tick = is_sync ? chg_e : (b_tick && r_reg.tx_pre == top);
		nb     = ucf_nbits(char_size);
		par_on = parity_mode[1];
		if (is_sync) begin
			rx_now = smp_e;
		end else begin
			rx_now = b_tick && (r_reg.rx_st == RX_START ? r_reg.rx_cnt == mid :
				r_reg.rx_cnt == top);
		end
	end

	always_comb begin
		r_next = r_reg;
		push   = 1'b0;
		entry  = '0;

		// clock pin sampling and master clock toggle
		r_next.xck_s1 = xfer_clk_pin_in;
		r_next.xck_s2 = r_reg.xck_s1;
		r_next.xck_d  = r_reg.xck_s2;
		if (!master) begin
			r_next.xck_int = 1'b0;
		end else if (b_tick) begin
			r_next.xck_int = ~r_reg.xck_int;
		end

		// async transmit prescaler
		if (b_tick) begin
			r_next.tx_pre = (r_reg.tx_pre >= top) ? 4'h0 : r_reg.tx_pre + 4'h1;
		end

		// one-entry transmit buffer
		if (tx_data_wr && !r_reg.tx_buf_full) begin
			r_next.tx_buf      = tx_data;
			r_next.tx_buf_full = 1'b1;
		end
		if (tx_complete_clr) begin
			r_next.txc = 1'b0;
		end

		if (tx_tick) begin
			case (r_reg.tx_st)
				TX_IDLE: begin
					if (r_reg.tx_buf_full && tx_enable) begin
						r_next.tx_shift    = r_reg.tx_buf;
						r_next.tx_par      = ucf_parity(r_reg.tx_buf, nb,
							parity_mode[0]);
						r_next.tx_buf_full = 1'b0;
						r_next.tx_line     = 1'b0;
						r_next.tx_st       = TX_START;
					end
				end
				TX_START: begin
					r_next.tx_line  = r_reg.tx_shift[0];
					r_next.tx_shift = {1'b0, r_reg.tx_shift[8:1]};
					r_next.tx_bitn  = 4'h1;
					r_next.tx_st    = TX_DATA;
				end
				TX_DATA: begin
					if (r_reg.tx_bitn == nb) begin
						if (par_on) begin
							r_next.tx_line = r_reg.tx_par;
							r_next.tx_st   = TX_PAR;
						end else begin
							r_next.tx_line = 1'b1;
							r_next.tx_st   = TX_STOP1;
						end
					end else begin
						r_next.tx_line  = r_reg.tx_shift[0];
						r_next.tx_shift = {1'b0, r_reg.tx_shift[8:1]};
						r_next.tx_bitn  = r_reg.tx_bitn + 4'h1;
					end
				end
				TX_PAR: begin
					r_next.tx_line = 1'b1;
					r_next.tx_st   = TX_STOP1;
				end
				TX_STOP1, TX_STOP2: begin
					if (r_reg.tx_st == TX_STOP1 && stop_bits_select) begin
						r_next.tx_st = TX_STOP2;
					end else if (r_reg.tx_buf_full) begin
						// back to back: the start bit follows the last stop bit
						r_next.tx_shift    = r_reg.tx_buf;
						r_next.tx_par      = ucf_parity(r_reg.tx_buf, nb,
							parity_mode[0]);
						r_next.tx_buf_full = 1'b0;
						r_next.tx_line     = 1'b0;
						r_next.tx_st       = TX_START;
					end else begin
						r_next.tx_line = 1'b1;
						r_next.tx_st   = TX_IDLE;
						r_next.txc     = 1'b1;
					end
				end
				default: begin
					r_next.tx_line = 1'b1;
					r_next.tx_st   = TX_IDLE;
				end
			endcase
		end

		// receiver
		if (!is_sync && b_tick && r_reg.rx_st != RX_IDLE) begin
			r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
		end
		if (rx_now) begin
			r_next.rx_cnt = 4'h0;
		end
		case (r_reg.rx_st)
			RX_IDLE: begin
				r_next.rx_shift = '0;
				r_next.rx_bitn  = 4'h0;
				r_next.rx_pe    = 1'b0;
				r_next.rx_cnt   = 4'h0;
				if (rx_enable && !serial_in_pin) begin
					if (is_sync && smp_e) begin
						r_next.rx_st = RX_DATA;
					end else if (!is_sync && b_tick) begin
						r_next.rx_st = RX_START;
					end
				end
			end
			RX_START: begin
				if (rx_now) begin
					// a start bit gone high by mid-bit was noise
					r_next.rx_st = serial_in_pin ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_now) begin
					r_next.rx_shift[r_reg.rx_bitn] = serial_in_pin;
					r_next.rx_bitn = r_reg.rx_bitn + 4'h1;
					if (r_reg.rx_bitn + 4'h1 == nb) begin
						r_next.rx_st = par_on ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (rx_now) begin
					r_next.rx_pe = serial_in_pin != ucf_parity(r_reg.rx_shift, nb,
						parity_mode[0]);
					r_next.rx_st = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_now) begin
					// only the first stop bit is looked at
					push  = 1'b1;
					entry = {r_reg.rx_pe, ~serial_in_pin, r_reg.rx_shift};
					r_next.rx_st = RX_IDLE;
				end
			end
			default: begin
				r_next.rx_st = RX_IDLE;
			end
		endcase
		if (!rx_enable) begin
			r_next.rx_st = RX_IDLE;
		end

		// two-entry receive buffer; pop before push, overrun set wins
		if (rx_read && r_reg.buf_cnt != 2'h0) begin
			r_next.buf0    = r_reg.buf1;
			r_next.buf_cnt = r_reg.buf_cnt - 2'h1;
		end
		if (rx_read) begin
			r_next.dor = 1'b0;
		end
		if (push) begin
			if (r_next.buf_cnt == `UCF_RXBUF_DEPTH) begin
				r_next.dor = 1'b1;
			end else begin
				if (r_next.buf_cnt == 2'h0) begin
					r_next.buf0 = entry;
				end else begin
					r_next.buf1 = entry;
				end
				r_next.buf_cnt = r_next.buf_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			r_reg         <= '0;
			r_reg.tx_line <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// pin drive and status
	assign xfer_clk_pin_out = r_reg.xck_int;
	assign xfer_clk_pin_oe  = master;
	assign serial_out_pin   = r_reg.tx_line;
	assign serial_out_oe    = tx_enable | r_reg.tx_buf_full |
		(r_reg.tx_st != TX_IDLE);
	assign tx_buf_empty     = ~r_reg.tx_buf_full;
	assign tx_complete_flag = r_reg.txc;
	assign rx_complete_flag = (r_reg.buf_cnt != 2'h0);
	assign rx_data          = r_reg.buf0[8:0];
	assign frame_error      = r_reg.buf0[`UCF_ENTRY_FE];
	assign parity_error     = r_reg.buf0[`UCF_ENTRY_PE];
	assign data_overrun     = r_reg.dor;

endmodule : ucf_usart

/* File: core/ucf_dummy_unused.sv */
// no logic lives in this file

/* File: test/ucf_usart_assertions.sv */
// port-level checks for the serial clock and framing block
`timescale 1ns/1ps
module ucf_usart_assertions (
	input wire logic ref_clk,          // clock
	input wire logic sys_rst,          // reset
	input wire logic tx_enable,        // tx on
	input wire logic rx_enable,        // rx on
	input wire logic tx_data_wr,       // write
	input wire logic tx_complete_clr,  // clear
	input wire logic rx_read,          // pop
	input wire logic sync_mode_select, // sync
	input wire logic xfer_clk_pin_dir, // master
	input wire logic xfer_clk_pin_out, // clock out
	input wire logic xfer_clk_pin_oe,  // clock drive
	input wire logic serial_out_pin,   // line
	input wire logic tx_buf_empty,     // empty
	input wire logic tx_complete_flag, // done
	input wire logic rx_complete_flag, // unread
	input wire logic data_overrun      // overrun
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_pin_dir: assert property (xfer_clk_pin_oe == (sync_mode_select & xfer_clk_pin_dir))
		else $error("clock pin drive does not follow mode");
	a_clk_quiet: assert property (!xfer_clk_pin_oe [*2] |-> !xfer_clk_pin_out)
		else $error("clock pin toggles outside master mode");
	a_reset_state: assert property ($past(sys_rst) |-> serial_out_pin && tx_buf_empty
		&& !tx_complete_flag && !rx_complete_flag && !data_overrun)
		else $error("state after reset wrong");
	a_buf_take: assert property (tx_data_wr && tx_buf_empty |=> !tx_buf_empty)
		else $error("write not taken into buffer");
	a_start_bit: assert property ($rose(tx_buf_empty) && !$past(sys_rst) |-> !serial_out_pin)
		else $error("frame load without start bit");
	a_txc_cause: assert property ($rose(tx_complete_flag) |-> tx_buf_empty && serial_out_pin)
		else $error("complete set with data pending");
	a_txc_hold: assert property (tx_complete_flag && !tx_complete_clr |=> tx_complete_flag)
		else $error("complete flag lost");
	a_ovr_hold: assert property (data_overrun && !rx_read |=> data_overrun)
		else $error("overrun lost without read");
	a_rx_hold: assert property (rx_complete_flag && !rx_read && rx_enable |=> rx_complete_flag)
		else $error("receive data lost without read");

	c_txc: cover property ($rose(tx_complete_flag));
	c_ovr: cover property ($rose(data_overrun));
	c_mclk: cover property ($rose(xfer_clk_pin_out));
endmodule : ucf_usart_assertions

bind ucf_usart ucf_usart_assertions u_ucf_usart_assertions (
	.ref_clk, .sys_rst, .tx_enable, .rx_enable, .tx_data_wr, .tx_complete_clr, .rx_read,
	.sync_mode_select, .xfer_clk_pin_dir, .xfer_clk_pin_out, .xfer_clk_pin_oe, .serial_out_pin,
	.tx_buf_empty, .tx_complete_flag, .rx_complete_flag, .data_overrun
);

/* File: test/ucf_remote_model.sv */
// remote serial transceiver, bit time in clock cycles
`timescale 1ns/1ps
module ucf_remote_model (
	input  wire logic ref_clk,  // system clock
	input  wire logic line_in,  // block transmit line
	output logic      line_out, // block receive line, idles high
	output logic      xck       // slave transfer clock
);
	int cyc = 0;

	initial line_out = 1'b1;
	initial xck = 1'b0;
	always @(posedge ref_clk) cyc <= cyc + 1;

	task automatic tk(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : tk

	// last bit cut short so a low stop bit cannot look like a new start
	task automatic send(input logic [15:0] b, input int n, input int bc);
		for (int i = 0; i < n; i++) begin
			line_out = b[i];
			tk((i == n - 1) ? bc * 3 / 4 : bc);
		end
		line_out = 1'b1;
	endtask : send

	// slave clock of 8 system clocks a period, well under a quarter of the system rate;
	// the first edge of each period is the change edge, the second the sample edge
	task automatic sxfer(input logic [15:0] b, input int n, input logic pol,
			output logic [15:0] r);
		r = '0;
		xck = pol;
		tk(4);
		for (int i = 0; i < n; i++) begin
			xck = ~pol;
			line_out = b[i];
			tk(4);
			xck = pol;
			tk(3);
			r[i] = line_in;
			tk(1);
		end
		line_out = 1'b1;
	endtask : sxfer

	task automatic grab(input int n, input int bc, output logic [15:0] b, output int t);
		int w;
		b = '0;
		for (w = 0; w < 4000 && line_in !== 1'b0; w++)
			tk(1);
		t = (w < 4000) ? cyc : -1;
		tk(bc / 2);
		for (int i = 0; i < n; i++) begin
			b[i] = line_in;
			if (i < n - 1)
				tk(bc);
		end
	endtask : grab
endmodule : ucf_remote_model

/* File: test/tb.sv */
// self-checking bench for the serial clock and framing block
`timescale 1ns/1ps
module tb;
	logic        ref_clk = 1'b0;
	logic        sys_rst, tx_enable, double_speed, sync_mode_select, xfer_clk_pin_dir;
	logic        baud_divisor_low_wr, tx_data_wr, tx_complete_clr, rx_read, stop_bits_select;
	logic        rx_enable, clock_polarity;
	wire  logic  xfer_clk_pin_in;
	logic [7:0]  baud_divisor_low;
	logic [3:0]  baud_divisor_high;
	logic [2:0]  char_size;
	logic [1:0]  parity_mode;
	logic [8:0]  tx_data, d;
	logic [15:0] e, g;
	wire  logic  serial_in_pin, serial_out_pin, xfer_clk_pin_out, xfer_clk_pin_oe, serial_out_oe;
	wire  logic  tx_buf_empty, tx_complete_flag, rx_complete_flag, frame_error, parity_error;
	wire  logic  data_overrun;
	wire  logic [8:0] rx_data;
	int          err_count = 0, cmp_count = 0, n, nb, bc, t1, t2;
	localparam logic [2:0] CSL [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};

	always #2 ref_clk = ~ref_clk;

	ucf_usart u_ucf_usart (
		.ref_clk, .sys_rst, .tx_enable, .rx_enable, .baud_divisor_low, .baud_divisor_high,
		.baud_divisor_low_wr, .double_speed, .sync_mode_select, .xfer_clk_pin_dir,
		.clock_polarity, .char_size, .parity_mode, .stop_bits_select, .tx_data, .tx_data_wr,
		.tx_complete_clr, .rx_read, .serial_in_pin, .xfer_clk_pin_in, .xfer_clk_pin_out,
		.xfer_clk_pin_oe, .serial_out_pin, .serial_out_oe, .tx_buf_empty, .tx_complete_flag,
		.rx_complete_flag, .rx_data, .frame_error, .parity_error, .data_overrun
	);
	ucf_remote_model u_ucf_remote_model (.ref_clk, .line_in(serial_out_pin),
		.line_out(serial_in_pin), .xck(xfer_clk_pin_in));

	task automatic tk(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : tk

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic hang(input int left);
		if (left <= 0) begin
			err_count++;
			test_done();
		end
	endtask : hang

	task automatic wr(input logic [8:0] v);
		tx_data = v;
		tx_data_wr = 1'b1;
		tk(1);
		tx_data_wr = 1'b0;
	endtask : wr

	task automatic rd();
		rx_read = 1'b1;
		tk(1);
		rx_read = 1'b0;
		tk(1);
	endtask : rd

	task automatic setdiv(input logic [11:0] v);
		{baud_divisor_high, baud_divisor_low} = v;
		baud_divisor_low_wr = 1'b1;
		tk(1);
		baud_divisor_low_wr = 1'b0;
	endtask : setdiv

	task automatic get(output logic [15:0] b, output int t);
		u_ucf_remote_model.grab(n, bc, b, t);
		hang(t + 1);
	endtask : get

	task automatic gap(output int k);
		logic v;
		v = xfer_clk_pin_out;
		for (k = 0; k < 600 && xfer_clk_pin_out === v; k++)
			tk(1);
		hang(600 - k);
	endtask : gap

	// expected line bits, start first, lsb first
	function automatic logic [15:0] frm(input logic [8:0] v, input int w, input logic [1:0] p,
			input logic s2, output int k);
		frm = '0;
		for (int i = 0; i < w; i++)
			frm[i + 1] = v[i];
		k = w + 1;
		if (p[1]) begin
			frm[k] = ^frm[9:1] ^ p[0];
			k++;
		end
		frm[k] = 1'b1;
		frm[k + 1] = s2;
		k = k + 1 + int'(s2);
	endfunction : frm

	initial begin
		{sys_rst, tx_enable, double_speed, sync_mode_select, xfer_clk_pin_dir} = 5'h10;
		{baud_divisor_low_wr, tx_data_wr, tx_complete_clr, rx_read, stop_bits_select} = 5'h0;
		{rx_enable, clock_polarity} = 2'h2;
		{baud_divisor_low, baud_divisor_high, char_size, parity_mode, tx_data} = '0;
		tk(12);
		sys_rst = 1'b0;
		chk(16'({serial_out_pin, tx_buf_empty, tx_complete_flag, rx_complete_flag,
			data_overrun, serial_out_oe}), 16'h30);
		tx_enable = 1'b1;
		setdiv(12'h001);
		// formats change only while idle
		for (int c = 0; c < 5; c++)
			for (int p = 0; p < 3; p++)
				for (int s = 0; s < 2; s++) begin
					char_size = CSL[c];
					parity_mode = (p == 0) ? 2'h0 : 2'(p + 1);
					stop_bits_select = s[0];
					double_speed = s[0] ^ p[0];
					bc = double_speed ? 16 : 32;
					nb = (c == 4) ? 9 : c + 5;
					d = 9'h1a5 ^ 9'(c * 37 + p * 11);
					e = frm(d, nb, parity_mode, stop_bits_select, n);
					tk(2);
					wr(d);
					get(g, t1);
					chk(g, e);
					tk(bc);
					chk(16'(tx_complete_flag), 16'h1);
					tx_complete_clr = 1'b1;
					tk(1);
					tx_complete_clr = 1'b0;
					u_ucf_remote_model.send(e, n, bc);
					tk(4);
					chk(16'({frame_error, parity_error, rx_complete_flag, rx_data}),
						16'({3'h1, 9'(d & ~(9'h1ff << nb))}));
					rd();
				end
		$display("test formats done");
		setdiv(12'h002);
		{char_size, parity_mode, stop_bits_select, double_speed} = 7'h32;
		bc = 48;
		e = frm(9'h05a, 8, 2'h0, 1'b1, n);
		wr(9'h05a);
		for (int w = 2000; tx_buf_empty !== 1'b1; w--) begin
			hang(w);
			tk(1);
		end
		// the first start bit began at this very edge
		t1 = u_ucf_remote_model.cyc;
		wr(9'h05a);
		chk(16'(tx_buf_empty), 16'h0);
		get(g, t2);
		chk(g, e);
		chk(16'(tx_complete_flag), 16'h0);
		get(g, t2);
		chk(16'(t2 - t1), 16'(n * bc));
		chk(g, e);
		tk(bc);
		chk(16'(tx_complete_flag), 16'h1);
		$display("test back to back done");
		{parity_mode, stop_bits_select} = 3'h4;
		e = frm(9'h03c, 8, 2'h2, 1'b0, n);
		u_ucf_remote_model.send(e, n, bc);
		u_ucf_remote_model.send(e ^ 16'h200, n, bc);
		u_ucf_remote_model.send(e ^ 16'h400, n, bc);
		tk(4);
		chk(16'(data_overrun), 16'h1);
		chk(16'({frame_error, parity_error, rx_data}), 16'h03c);
		rd();
		chk(16'({frame_error, parity_error, data_overrun, rx_data}), 16'h43c);
		rd();
		chk(16'(rx_complete_flag), 16'h0);
		u_ucf_remote_model.send(e ^ 16'h400, n, bc);
		tk(4);
		chk(16'({frame_error, parity_error, rx_data}), 16'h43c);
		rd();
		$display("test receive errors done");
		setdiv(12'h101);
		{sync_mode_select, xfer_clk_pin_dir, double_speed} = 3'h6;
		tk(1);
		chk(16'(xfer_clk_pin_oe), 16'h1);
		gap(t1);
		gap(t1);
		chk(16'(t1), 16'h102);
		sync_mode_select = 1'b0;
		tk(2);
		chk(16'({xfer_clk_pin_oe, xfer_clk_pin_out}), 16'h0);
		$display("test sync master done");
		// slave mode; a short receiver disable drops any half-seen frame
		{sync_mode_select, xfer_clk_pin_dir, rx_enable} = 3'h4;
		tk(1);
		rx_enable = 1'b1;
		chk(16'({xfer_clk_pin_oe, serial_out_oe}), 16'h1);
		for (int pol = 0; pol < 2; pol++) begin
			clock_polarity = pol[0];
			d = pol[0] ? 9'h0a3 : 9'h05c;
			e = frm(d, 8, parity_mode, 1'b0, n);
			wr(d);
			u_ucf_remote_model.sxfer(e, n, pol[0], g);
			chk(g, e);
			chk(16'({frame_error, parity_error, rx_complete_flag, rx_data}),
				16'({3'h1, d}));
			rd();
		end
		$display("test sync slave done");
		test_done();
	end
endmodule : tb
